// ===== backchannel_far_end.sv
// Far end of the back channel: answers each request across the link
`timescale 1ns/10ps
`include "serial_ctrl_regs.vh"
module backchannel_far_end #(
  parameter [7:0] READ_BYTE = 8'hA5
) (
  input  wire       req_valid_in,
  input  wire [1:0] req_kind_in,
  input  wire [7:0] req_data_in,
  input  wire       slow_in,
  output reg        link_clk_out,
  output reg        resp_valid_out,
  output reg        resp_ack_out,
  output reg  [7:0] resp_data_out,
  output reg  [7:0] last_start_out,
  output reg  [7:0] last_write_out,
  output reg  [7:0] n_start_out,
  output reg  [7:0] n_stop_out
);
  // Link clock only runs while a frame is in flight and for two ticks after it is released
  task link_tick;
    begin
      #200 link_clk_out = 1'b1;
      #200 link_clk_out = 1'b0;
    end
  endtask
  initial begin
    link_clk_out = 1'b0;
    resp_valid_out = 1'b0;
    resp_ack_out = 1'b0;
    resp_data_out = 8'h5A;
    last_start_out = 8'h00;
    last_write_out = 8'h00;
    n_start_out = 8'h00;
    n_stop_out = 8'h00;
    forever begin
      wait (req_valid_in === 1'b1);
      repeat (slow_in ? 12 : 2) link_tick;
      if (req_kind_in == `KIND_START) begin
        last_start_out = req_data_in;
        n_start_out = n_start_out + 8'h01;
      end
      if (req_kind_in == `KIND_WRITE) last_write_out = req_data_in;
      if (req_kind_in == `KIND_STOP) n_stop_out = n_stop_out + 8'h01;
      resp_ack_out = 1'b1;
      resp_data_out = (req_kind_in == `KIND_READ) ? READ_BYTE : ~resp_data_out;
      resp_valid_out = 1'b1;
      while (req_valid_in === 1'b1) link_tick;
      // Released answer lines never keep the last value
      resp_valid_out = 1'b0;
      resp_ack_out = 1'b0;
      resp_data_out = ~resp_data_out;
      link_tick;
      link_tick;
    end
  end
endmodule

// ===== pin_sync.v
// Two flip-flop synchroniser for a group of asynchronous inputs
`timescale 1ns/10ps
module pin_sync #(
  parameter WIDTH = 1
) (
  // Clock and reset
  input  wire             clk_sys_in,
  input  wire             srst_in,
  // Asynchronous inputs and their synchronised copies
  input  wire [WIDTH-1:0] async_in,
  output reg  [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] meta_reg;

  always @(posedge clk_sys_in) begin
    if (srst_in) begin
      meta_reg <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule

// ===== serial_control_target.v
// Serial control target: strap address, direct port addresses, alias pass-through to the back channel
`timescale 1ns/10ps
`include "serial_ctrl_regs.vh"
module serial_control_target #(
  parameter BOOT_WAIT_CYCLES = (`BOOT_WAIT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
) (
  // Clock and reset
  input  wire       clk_sys_in,
  input  wire       srst_in,
  // Power-down and straps
  input  wire       power_down_n_in,
  input  wire [2:0] address_strap_pin_in,
  input  wire       mode_strap_in,
  // Serial control bus, open drain
  input  wire       scl_in,
  output wire       scl_out,
  output wire       scl_oe_out,
  input  wire       sda_in,
  output wire       sda_out,
  output wire       sda_oe_out,
  // Receive port status and GPIO
  input  wire [1:0] port_lock_in,
  input  wire [3:0] gpio_in,
  // Back channel request side
  output reg        bc_req_valid_out,
  output reg  [1:0] bc_req_kind_out,
  output reg  [7:0] bc_req_data_out,
  output reg  [0:0] bc_req_port_out,
  // Back channel answer side, timed by the link clock
  input  wire       link_clk_in,
  input  wire       bc_resp_valid_in,
  input  wire       bc_resp_ack_in,
  input  wire [7:0] bc_resp_data_in,
  // Back channel side information
  output wire [1:0] backchannel_rate_select_out,
  output reg  [3:0] bc_gpio_out,
  output wire [7:0] bc_caps_out,
  output wire       proxy_ctrl_en_out
);

  localparam [15:0] BOOT_LIMIT = BOOT_WAIT_CYCLES[15:0];
  localparam [5:0] S_IDLE = 6'h01;
  localparam [5:0] S_ADDR = 6'h02;
  localparam [5:0] S_REG  = 6'h04;
  localparam [5:0] S_WR   = 6'h08;
  localparam [5:0] S_RD   = 6'h10;
  localparam [5:0] S_WAIT = 6'h20;

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisation
  wire [23:0] sync_w;
  pin_sync #(.WIDTH(24)) u_sync (
    .clk_sys_in (clk_sys_in),
    .srst_in    (srst_in),
    .async_in   ({scl_in, sda_in, power_down_n_in, address_strap_pin_in, mode_strap_in, port_lock_in,
                  link_clk_in, bc_resp_valid_in, bc_resp_ack_in, bc_resp_data_in, gpio_in}),
    .sync_out   (sync_w)
  );
  wire       scl_s   = sync_w[23];
  wire       sda_s   = sync_w[22];
  wire       pdn_s   = sync_w[21];
  wire [2:0] strap_s = sync_w[20:18];
  wire       mode_s  = sync_w[17];
  wire [1:0] lock_s  = sync_w[16:15];
  wire       link_s  = sync_w[14];
  wire       rval_s  = sync_w[13];
  wire       rack_s  = sync_w[12];
  wire [7:0] rdat_s  = sync_w[11:4];
  wire [3:0] gpio_s  = sync_w[3:0];

  // Power-down acts as a block reset so the strap is caught afresh per power-up
  wire rst = srst_in | ~pdn_s;

  ////////////////////////////////////////////////////////////////////////////
  // State
  reg  [7:0]  dev_addr_reg, gen_cfg_reg, port_sel_reg;
  reg  [7:0]  bc_cfg_reg [0:1];
  reg  [7:0]  direct_reg [0:1];
  reg  [7:0]  alias_reg  [0:15];
  reg  [7:0]  real_reg   [0:15];
  reg  [15:0] boot_cnt_reg;
  reg         booted_reg, mode_strap_reg;
  reg  [5:0]  state_reg;
  reg  [3:0]  cnt_reg;
  reg  [7:0]  shift_reg, tx_reg, ptr_reg;
  reg         scl_prev_reg, sda_prev_reg, link_prev_reg;
  reg         ack_drv_reg, stretch_reg, rw_reg, remote_reg, direct_reg_hit, host_nack_reg;
  reg  [0:0]  page_port_reg;
  reg         pend_reg, armed_reg;
  reg  [1:0]  pend_kind_reg;
  reg  [7:0]  pend_data_reg;
  integer     i;
  integer     j;

  wire scl_rise = scl_s & ~scl_prev_reg;
  wire scl_fall = ~scl_s & scl_prev_reg;
  wire start_c  = scl_s & scl_prev_reg & ~sda_s & sda_prev_reg;
  wire stop_c   = scl_s & scl_prev_reg & sda_s & ~sda_prev_reg;
  wire resp_take = bc_req_valid_out & armed_reg & link_s & ~link_prev_reg & rval_s;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode
  wire [6:0] in_addr = shift_reg[7:1];
  wire [1:0] direct_hit;
  wire [1:0] direct_en;
  wire [7:0] alias_hit;
  wire       dir_any  = |direct_hit;
  wire [0:0] dir_port = direct_hit[1] ? 1'b1 : 1'b0;
  // Direct address fixes the page, otherwise the read page of the port select
  wire [0:0] look_port = dir_any ? dir_port : port_sel_reg[`PORT_SEL_RD_BIT];
  wire       prim_hit  = (in_addr == dev_addr_reg[7:1]);
  reg  [6:0] real_addr;

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_port
      assign direct_en[g]  = (direct_reg[g][7:1] != 7'h00);
      assign direct_hit[g] = direct_en[g] & (in_addr == direct_reg[g][7:1]);
      assign backchannel_rate_select_out[g] = (bc_cfg_reg[g][1:0] == `RATE_FAST) ? 1'b0 :
                                              (bc_cfg_reg[g][1:0] == `RATE_SLOW) ? 1'b1 : mode_strap_reg;
    end
    for (g = 0; g < 8; g = g + 1) begin : g_alias
      assign alias_hit[g] = (alias_reg[look_port * 8 + g][7:1] == in_addr) &&
                            (alias_reg[look_port * 8 + g][7:1] != 7'h00);
    end
  endgenerate

  always @* begin
    real_addr = 7'h00;
    for (j = 0; j < 8; j = j + 1) begin
      if (alias_hit[j]) begin
        real_addr = real_reg[look_port * 8 + j][7:1];
      end
    end
  end

  wire pass_ok = bc_cfg_reg[look_port][`BC_PASS_BIT] & lock_s[look_port];

  ////////////////////////////////////////////////////////////////////////////
  // Register read mux
  wire [7:0] tbl_off = ptr_reg - `REG_ALIAS_BASE;
  wire [3:0] tbl_idx = {page_port_reg, tbl_off[2:0]};
  reg  [7:0] rd_data;
  always @* begin
    rd_data = 8'h00;
    case (ptr_reg)
      `REG_DEV_ADDR:     rd_data = dev_addr_reg;
      `REG_GEN_CFG:      rd_data = gen_cfg_reg;
      `REG_PORT_SEL:     rd_data = port_sel_reg;
      `REG_BC_CFG:       rd_data = bc_cfg_reg[page_port_reg];
      `REG_PORT0_DIRECT: rd_data = direct_reg[0];
      `REG_PORT1_DIRECT: rd_data = direct_reg[1];
      default: begin
        if (tbl_off < 8'h08) begin
          rd_data = alias_reg[tbl_idx];
        end else if (tbl_off < 8'h10) begin
          rd_data = real_reg[tbl_idx];
        end
      end
    endcase
  end

  // Write page: direct address hits one port, otherwise the write mask
  wire [1:0] wr_mask = direct_reg_hit ? (page_port_reg[0] ? 2'h2 : 2'h1) : port_sel_reg[1:0];

  ////////////////////////////////////////////////////////////////////////////
  // Boot, registers and target sequencer
  always @(posedge clk_sys_in) begin
    scl_prev_reg  <= scl_s;
    sda_prev_reg  <= sda_s;
    link_prev_reg <= link_s;
    bc_gpio_out   <= gpio_s;
    if (rst) begin
      dev_addr_reg <= 8'h00;
      gen_cfg_reg <= `GEN_CFG_RESET;
      port_sel_reg <= `PORT_SEL_RESET;
      for (i = 0; i < 2; i = i + 1) begin
        bc_cfg_reg[i] <= `BC_CFG_RESET;
        direct_reg[i] <= `DIRECT_RESET;
      end
      for (i = 0; i < 16; i = i + 1) begin
        alias_reg[i] <= 8'h00;
        real_reg[i] <= 8'h00;
      end
      boot_cnt_reg <= 16'h0000;
      booted_reg <= 1'b0;
      mode_strap_reg <= 1'b0;
      state_reg <= S_IDLE;
      cnt_reg <= 4'h0;
      {shift_reg, tx_reg, ptr_reg} <= 24'h000000;
      {ack_drv_reg, stretch_reg, rw_reg, remote_reg, direct_reg_hit, host_nack_reg} <= 6'h00;
      page_port_reg <= 1'b0;
      {pend_reg, armed_reg} <= 2'h0;
      pend_kind_reg <= `KIND_START;
      pend_data_reg <= 8'h00;
      bc_req_valid_out <= 1'b0;
      bc_req_kind_out <= `KIND_START;
      bc_req_data_out <= 8'h00;
      bc_req_port_out <= 1'b0;
    end else begin
      // Strap sampled after the power-up wait, once per power-up
      if (!booted_reg) begin
        boot_cnt_reg <= boot_cnt_reg + 16'h0001;
        if (boot_cnt_reg == BOOT_LIMIT) begin
          booted_reg <= 1'b1;
          mode_strap_reg <= mode_s;
          // Strap level decode, kept in register 0x00
          case (strap_s)
            3'h0: dev_addr_reg <= {`ADDR_LEVEL0, 1'b0};
            3'h1: dev_addr_reg <= {`ADDR_LEVEL1, 1'b0};
            3'h2: dev_addr_reg <= {`ADDR_LEVEL2, 1'b0};
            3'h3: dev_addr_reg <= {`ADDR_LEVEL3, 1'b0};
            3'h4: dev_addr_reg <= {`ADDR_LEVEL4, 1'b0};
            3'h5: dev_addr_reg <= {`ADDR_LEVEL5, 1'b0};
            3'h6: dev_addr_reg <= {`ADDR_LEVEL6, 1'b0};
            default: dev_addr_reg <= {`ADDR_LEVEL7, 1'b0};
          endcase
        end
      end

      // Four-phase back channel handshake; answer taken on a link clock rise
      if (bc_req_valid_out && !rval_s) begin
        armed_reg <= 1'b1;
      end
      if (resp_take) begin
        bc_req_valid_out <= 1'b0;
      end else if (pend_reg && !bc_req_valid_out && !rval_s) begin
        bc_req_valid_out <= 1'b1;
        bc_req_kind_out <= pend_kind_reg;
        bc_req_data_out <= pend_data_reg;
        bc_req_port_out <= page_port_reg;
        armed_reg <= 1'b0;
        pend_reg <= 1'b0;
      end

      if (scl_rise && cnt_reg < 4'h8) begin
        shift_reg <= {shift_reg[6:0], sda_s};
      end
      if (scl_rise && cnt_reg == 4'h8) begin
        host_nack_reg <= sda_s;
      end

      // SDA gets one cycle of setup before a stretched clock is let go
      if (stretch_reg && state_reg != S_WAIT) begin
        stretch_reg <= 1'b0;
      end

      if (stop_c) begin
        state_reg <= S_IDLE;
        ack_drv_reg <= 1'b0;
        // Remote session closed by the host's stop
        if (remote_reg) begin
          pend_reg <= 1'b1;
          pend_kind_reg <= `KIND_STOP;
          remote_reg <= 1'b0;
        end
      end else if (start_c && booted_reg) begin
        state_reg <= S_ADDR;
        // The start's own clock fall wraps this to zero
        cnt_reg <= 4'hF;
        ack_drv_reg <= 1'b0;
      end else if (state_reg == S_WAIT) begin
        if (resp_take) begin
          // Answer in; the clock is let go one cycle later
          if (pend_kind_reg == `KIND_READ) begin
            tx_reg <= rdat_s;
            state_reg <= S_RD;
          end else if (rack_s) begin
            ack_drv_reg <= 1'b1;
            state_reg <= (pend_kind_reg == `KIND_START && rw_reg) ? S_RD : S_WR;
          end else begin
            state_reg <= S_IDLE;
          end
        end
      end else if (scl_fall && state_reg != S_IDLE) begin
        if (cnt_reg == 4'h7) begin
          cnt_reg <= 4'h8;
          case (state_reg)
            S_ADDR: begin
              rw_reg <= shift_reg[0];
              // Only known addresses are acknowledged, direct ones reach shared registers
              if (prim_hit || dir_any) begin
                ack_drv_reg <= 1'b1;
                direct_reg_hit <= dir_any;
                page_port_reg <= look_port;
                state_reg <= shift_reg[0] ? S_RD : S_REG;
              end else if (pass_ok && |alias_hit) begin
                // Hold the clock low while the address crosses the link, repeated start too
                remote_reg <= 1'b1;
                page_port_reg <= look_port;
                stretch_reg <= 1'b1;
                pend_reg <= 1'b1;
                pend_kind_reg <= `KIND_START;
                pend_data_reg <= {real_addr, shift_reg[0]};
                state_reg <= S_WAIT;
              end else begin
                state_reg <= S_IDLE;
              end
            end
            S_REG: begin
              ptr_reg <= shift_reg;
              ack_drv_reg <= 1'b1;
              state_reg <= S_WR;
            end
            S_WR: begin
              if (remote_reg) begin
                stretch_reg <= 1'b1;
                pend_reg <= 1'b1;
                pend_kind_reg <= `KIND_WRITE;
                pend_data_reg <= shift_reg;
                state_reg <= S_WAIT;
              end else begin
                ack_drv_reg <= 1'b1;
                ptr_reg <= ptr_reg + 8'h01;
                case (ptr_reg)
                  `REG_DEV_ADDR:     dev_addr_reg <= shift_reg;
                  `REG_GEN_CFG:      gen_cfg_reg <= shift_reg;
                  `REG_PORT_SEL:     port_sel_reg <= shift_reg;
                  `REG_PORT0_DIRECT: direct_reg[0] <= shift_reg;
                  `REG_PORT1_DIRECT: direct_reg[1] <= shift_reg;
                  default: begin
                    for (i = 0; i < 2; i = i + 1) begin
                      if (wr_mask[i]) begin
                        if (ptr_reg == `REG_BC_CFG) begin
                          bc_cfg_reg[i] <= shift_reg;
                        end else if (tbl_off < 8'h08) begin
                          alias_reg[{i[0], tbl_off[2:0]}] <= shift_reg;
                        end else if (tbl_off < 8'h10) begin
                          real_reg[{i[0], tbl_off[2:0]}] <= shift_reg;
                        end
                      end
                    end
                  end
                endcase
              end
            end
            default: begin
            end
          endcase
        end else if (cnt_reg == 4'h8) begin
          cnt_reg <= 4'h0;
          ack_drv_reg <= 1'b0;
          if (state_reg == S_RD) begin
            if (host_nack_reg) begin
              state_reg <= S_IDLE;
            end else if (remote_reg) begin
              stretch_reg <= 1'b1;
              pend_reg <= 1'b1;
              pend_kind_reg <= `KIND_READ;
              state_reg <= S_WAIT;
            end else begin
              // Local read data ready at once
              tx_reg <= rd_data;
              ptr_reg <= ptr_reg + 8'h01;
            end
          end
        end else begin
          cnt_reg <= cnt_reg + 4'h1;
          if (state_reg == S_RD) begin
            tx_reg <= {tx_reg[6:0], 1'b0};
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pins and side outputs
  // Open-drain pins, only pulled low
  assign scl_out    = 1'b0;
  assign sda_out    = 1'b0;
  // Stretch during the remote wait and one cycle past it, never otherwise
  assign scl_oe_out = stretch_reg;
  assign sda_oe_out = ack_drv_reg | ((state_reg == S_RD) && (cnt_reg < 4'h8) && !tx_reg[7]);
  assign proxy_ctrl_en_out = gen_cfg_reg[`GEN_PROXY_EN_BIT];
  // Capabilities advertised over the back channel
  assign bc_caps_out = gen_cfg_reg;

endmodule

// ===== serial_control_target_properties.sv
// Port checker of the serial control target, bound to every instance
`timescale 1ns/10ps
`include "serial_ctrl_regs.vh"
module serial_control_target_properties #(
  parameter BOOT_WAIT_CYCLES = 16
) (
  input wire       clk_sys_in,
  input wire       srst_in,
  input wire       power_down_n_in,
  input wire [2:0] address_strap_pin_in,
  input wire       mode_strap_in,
  input wire       scl_in,
  input wire       scl_out,
  input wire       scl_oe_out,
  input wire       sda_in,
  input wire       sda_out,
  input wire       sda_oe_out,
  input wire [1:0] port_lock_in,
  input wire [3:0] gpio_in,
  input wire       bc_req_valid_out,
  input wire [1:0] bc_req_kind_out,
  input wire [7:0] bc_req_data_out,
  input wire [0:0] bc_req_port_out,
  input wire       link_clk_in,
  input wire       bc_resp_valid_in,
  input wire       bc_resp_ack_in,
  input wire [7:0] bc_resp_data_in,
  input wire [1:0] backchannel_rate_select_out,
  input wire [3:0] bc_gpio_out,
  input wire [7:0] bc_caps_out,
  input wire       proxy_ctrl_en_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (srst_in);
  ////////////////////////////////////////////////////////////////////////////////
  AST_OPEN_DRAIN: assert property (scl_out == 1'b0 && sda_out == 1'b0)
    else $error("bus pin driven high");
  AST_RESET_QUIET: assert property ($fell(srst_in) |-> !scl_oe_out && !sda_oe_out && !bc_req_valid_out)
    else $error("output active straight after reset");
  AST_SDA_UNDER_LOW_CLOCK: assert property ($changed(sda_oe_out) |-> !scl_in)
    else $error("data line changed while clock high");
  AST_PROXY_FOLLOWS_CAPS: assert property (proxy_ctrl_en_out == bc_caps_out[`GEN_PROXY_EN_BIT])
    else $error("proxy enable differs from its register bit");
  AST_GPIO_CARRIED: assert property ($stable(gpio_in) [*5] |-> bc_gpio_out == gpio_in)
    else $error("gpio state not carried");
  // Stretching is only for link traffic, so a request must follow soon
  AST_STRETCH_FOR_REMOTE: assert property ($rose(scl_oe_out) |-> ##[0:40] bc_req_valid_out)
    else $error("clock stretched with no link request");
  AST_SETUP_BEFORE_RELEASE: assert property ($fell(scl_oe_out) |-> $stable(sda_oe_out))
    else $error("data line changed as stretched clock was released");
  AST_REQ_STEADY: assert property (bc_req_valid_out && $past(bc_req_valid_out) |->
    $stable(bc_req_kind_out) && $stable(bc_req_data_out) && $stable(bc_req_port_out))
    else $error("request changed while pending");
  AST_REQ_RELEASE: assert property (bc_req_valid_out && bc_resp_valid_in |-> ##[1:30] !bc_req_valid_out)
    else $error("request not withdrawn after answer");
  AST_LINK_NEEDS_LOCK: assert property ($rose(bc_req_valid_out) && bc_req_kind_out == `KIND_START
    |-> port_lock_in[bc_req_port_out])
    else $error("link start toward unlocked port");
  ////////////////////////////////////////////////////////////////////////////////
  cover property ($rose(bc_req_valid_out) && bc_req_kind_out == `KIND_READ);
  cover property ($rose(scl_oe_out));
  cover property ($rose(sda_oe_out));
endmodule
bind serial_control_target serial_control_target_properties #(.BOOT_WAIT_CYCLES(BOOT_WAIT_CYCLES)) chk (.*);

// ===== serial_ctrl_regs.vh
// Register offsets, field positions, reset values and timing of the serial control target
`ifndef SERIAL_CTRL_REGS_VH
`define SERIAL_CTRL_REGS_VH

`define REG_DEV_ADDR      8'h00
`define REG_GEN_CFG       8'h02
`define REG_PORT_SEL      8'h4C
`define REG_BC_CFG        8'h58
`define REG_ALIAS_BASE    8'h5C
`define REG_PORT0_DIRECT  8'hF8
`define REG_PORT1_DIRECT  8'hF9

`define GEN_PROXY_EN_BIT  5
`define BC_PASS_BIT       6
`define PORT_SEL_RD_BIT   4

`define GEN_CFG_RESET     8'h00
`define PORT_SEL_RESET    8'h01
`define BC_CFG_RESET      8'h00
`define DIRECT_RESET      8'h00

`define RATE_FAST         2'h1
`define RATE_SLOW         2'h2

`define ADDR_LEVEL0       7'h30
`define ADDR_LEVEL1       7'h32
`define ADDR_LEVEL2       7'h34
`define ADDR_LEVEL3       7'h36
`define ADDR_LEVEL4       7'h38
`define ADDR_LEVEL5       7'h3A
`define ADDR_LEVEL6       7'h3C
`define ADDR_LEVEL7       7'h3D

`define KIND_START        2'h0
`define KIND_WRITE        2'h1
`define KIND_READ         2'h2
`define KIND_STOP         2'h3

`define CLK_PERIOD_NS     50
`define BOOT_WAIT_NS      1000000

`endif

// ===== test_serial_control_target.sv
// Testbench of the serial control target with a back channel far end
`timescale 1ns/10ps
`include "serial_ctrl_regs.vh"
module test_serial_control_target;
  logic       clk_sys_in, srst_in, power_down_n_in, mode_strap_in, scl_h, sda_h, slow;
  logic [2:0] address_strap_pin_in;
  logic [1:0] port_lock_in;
  logic [3:0] gpio_in;
  logic [7:0] x, n_stretch = 8'h00;
  logic       n0, n1;
  int         n_errors = 0, check_count = 0, lv;
  wire        scl_out, scl_oe_out, sda_out, sda_oe_out, bc_req_valid_out, proxy_ctrl_en_out;
  wire        link_clk_in, bc_resp_valid_in, bc_resp_ack_in;
  wire  [1:0] bc_req_kind_out, backchannel_rate_select_out;
  wire  [7:0] bc_req_data_out, bc_resp_data_in, bc_caps_out, last_start, last_write, n_start, n_stop;
  wire  [0:0] bc_req_port_out;
  wire  [3:0] bc_gpio_out;
  // Open drain: pulled high unless someone pulls low
  wire        scl_in = scl_h & ~scl_oe_out;
  wire        sda_in = sda_h & ~sda_oe_out;
  logic [6:0] strap_tab [8] = '{7'h30, 7'h32, 7'h34, 7'h36, 7'h38, 7'h3A, 7'h3C, 7'h3D};
  ////////////////////////////////////////////////////////////////////////////////
  serial_control_target #(.BOOT_WAIT_CYCLES(16)) dut (
    .clk_sys_in(clk_sys_in), .srst_in(srst_in), .power_down_n_in(power_down_n_in),
    .address_strap_pin_in(address_strap_pin_in), .mode_strap_in(mode_strap_in),
    .scl_in(scl_in), .scl_out(scl_out), .scl_oe_out(scl_oe_out),
    .sda_in(sda_in), .sda_out(sda_out), .sda_oe_out(sda_oe_out),
    .port_lock_in(port_lock_in), .gpio_in(gpio_in), .bc_req_valid_out(bc_req_valid_out),
    .bc_req_kind_out(bc_req_kind_out), .bc_req_data_out(bc_req_data_out), .bc_req_port_out(bc_req_port_out),
    .link_clk_in(link_clk_in), .bc_resp_valid_in(bc_resp_valid_in), .bc_resp_ack_in(bc_resp_ack_in),
    .bc_resp_data_in(bc_resp_data_in), .backchannel_rate_select_out(backchannel_rate_select_out),
    .bc_gpio_out(bc_gpio_out), .bc_caps_out(bc_caps_out), .proxy_ctrl_en_out(proxy_ctrl_en_out));
  backchannel_far_end far (.req_valid_in(bc_req_valid_out), .req_kind_in(bc_req_kind_out),
    .req_data_in(bc_req_data_out), .slow_in(slow), .link_clk_out(link_clk_in), .resp_valid_out(bc_resp_valid_in),
    .resp_ack_out(bc_resp_ack_in), .resp_data_out(bc_resp_data_in), .last_start_out(last_start),
    .last_write_out(last_write), .n_start_out(n_start), .n_stop_out(n_stop));
  initial begin
    clk_sys_in = 1'b0;
    forever #25 clk_sys_in = ~clk_sys_in;
  end
  always @(posedge clk_sys_in) begin
    if (scl_oe_out === 1'b1 && n_stretch != 8'hFF) n_stretch <= n_stretch + 8'h01;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task tick(input int n);
    repeat (n) @(posedge clk_sys_in);
  endtask
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task summarize;
    $display("checks %0d, errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task start_c;
    sda_h <= 1'b1;
    tick(5);
    scl_h <= 1'b1;
    tick(10);
    sda_h <= 1'b0;
    tick(10);
    scl_h <= 1'b0;
    tick(5);
  endtask
  task stop_c;
    sda_h <= 1'b0;
    tick(5);
    scl_h <= 1'b1;
    tick(10);
    sda_h <= 1'b1;
    tick(20);
  endtask
  // Nine bits at 1 MHz; a held-low clock is waited out, bounded
  task automatic byte_io(input logic [7:0] tx, input logic host_ack, output logic [7:0] rx, output logic nack);
    logic [8:0] sh;
    int         i, w;
    sh = {tx, host_ack};
    for (i = 8; i >= 0; i--) begin
      sda_h <= sh[i];
      tick(5);
      scl_h <= 1'b1;
      w = 0;
      do begin
        tick(1);
        w++;
      end while (scl_in !== 1'b1 && w < 4000);
      tick(4);
      @(negedge clk_sys_in);
      sh[i] = sda_in;
      tick(5);
      scl_h <= 1'b0;
      tick(5);
    end
    rx = sh[8:1];
    nack = sh[0];
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] r, input logic [7:0] d);
    logic [7:0] y;
    logic       k0, k1, k2;
    start_c;
    byte_io({a, 1'b0}, 1'b1, y, k0);
    byte_io(r, 1'b1, y, k1);
    byte_io(d, 1'b1, y, k2);
    stop_c;
    check("write acks", 8'h00, {5'h00, k0, k1, k2});
  endtask
  task automatic rdchk(input string what, input logic [6:0] a, input logic [7:0] r, input logic [7:0] e);
    logic [7:0] y;
    logic       k0, k1, k2;
    start_c;
    byte_io({a, 1'b0}, 1'b1, y, k0);
    byte_io(r, 1'b1, y, k1);
    start_c;
    byte_io({a, 1'b1}, 1'b1, y, k2);
    byte_io(8'hFF, 1'b1, y, k1);
    stop_c;
    check("read acks", 8'h00, {6'h00, k0, k2});
    check(what, e, y);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    srst_in = 1'b1;
    power_down_n_in = 1'b1;
    address_strap_pin_in = 3'h0;
    mode_strap_in = 1'b0;
    // Ports stay locked for all link traffic
    port_lock_in = 2'b11;
    gpio_in = 4'h0;
    scl_h = 1'b1;
    sda_h = 1'b1;
    slow = 1'b0;
    tick(10);
    srst_in <= 1'b0;
    for (lv = 0; lv < 8; lv++) begin
      address_strap_pin_in <= lv[2:0];
      power_down_n_in <= 1'b0;
      tick(5);
      power_down_n_in <= 1'b1;
      tick(40);
      rdchk("primary address", strap_tab[lv], 8'h00, {strap_tab[lv], 1'b0});
    end
    address_strap_pin_in <= 3'h0;
    tick(10);
    rdchk("held address", 7'h3D, 8'h00, 8'h7A);
    start_c;
    byte_io(8'hA0, 1'b1, x, n0);
    stop_c;
    check("stray address nack", 8'h01, {7'h00, n0});
    wr(7'h3D, 8'hF8, 8'hA0);
    wr(7'h3D, 8'hF9, 8'hA2);
    rdchk("shared via port0", 7'h50, 8'h00, 8'h7A);
    wr(7'h50, 8'h58, 8'h02);
    wr(7'h51, 8'h58, 8'h41);
    rdchk("port0 config", 7'h50, 8'h58, 8'h02);
    rdchk("port1 config", 7'h51, 8'h58, 8'h41);
    check("rate select", 8'h01, {6'h00, backchannel_rate_select_out});
    wr(7'h3D, 8'h02, 8'h20);
    check("capabilities", 8'h20, bc_caps_out);
    check("proxy enable", 8'h01, {7'h00, proxy_ctrl_en_out});
    gpio_in <= 4'hA;
    tick(6);
    check("gpio state", 8'h0A, {4'h0, bc_gpio_out});
    check("local stretch", 8'h00, n_stretch);
    wr(7'h3D, 8'h4C, 8'h12);
    wr(7'h3D, 8'h5C, 8'h88);
    wr(7'h3D, 8'h64, 8'h42);
    start_c;
    byte_io(8'h88, 1'b1, x, n0);
    byte_io(8'h07, 1'b1, x, n1);
    stop_c;
    tick(100);
    check("remote acks", 8'h00, {6'h00, n0, n1});
    check("remote address", 8'h42, last_start);
    check("remote byte", 8'h07, last_write);
    check("remote stops", 8'h01, n_stop);
    slow <= 1'b1;
    start_c;
    byte_io(8'h89, 1'b1, x, n0);
    byte_io(8'hFF, 1'b1, x, n1);
    stop_c;
    tick(200);
    check("remote read", 8'hA5, x);
    check("remote read start", 8'h43, last_start);
    check("stretched", 8'h01, {7'h00, n_stretch != 8'h00});
    wr(7'h51, 8'h58, 8'h01);
    start_c;
    byte_io(8'h88, 1'b1, x, n0);
    stop_c;
    tick(100);
    check("closed pass nack", 8'h01, {7'h00, n0});
    check("closed pass starts", 8'h02, n_start);
    summarize;
  end
  // Full run needs about 18000 cycles
  initial begin
    #3000000;
    n_errors++;
    summarize;
  end
endmodule
